// [design/scs_pkg.sv]
// Shared constants and types for the clock-stop serial port
package scs_pkg;

  // ----------------------------------------------------------------
  // Timing base
  // ----------------------------------------------------------------
  // Core clock is the slow peripheral clock, so one cycle is one P
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned P_NS          = 50;
  localparam int unsigned CYC_PER_P     = (P_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Configuration encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] STOP_NO_DELAY   = 2'h2;  // Code 10b
  localparam logic [1:0] STOP_HALF_DELAY = 2'h3;  // Code 11b
  localparam logic       DIR_OUT         = 1'h1;
  localparam logic       DIR_IN          = 1'h0;
  localparam logic       FRAME_POL_LOW   = 1'h1;  // Active-low select pins
  localparam logic [7:0] DIV_ZERO        = 8'h00;
  localparam logic [7:0] SLAVE_DIV       = 8'h01;  // Half the core clock
  localparam logic       SLAVE_SRC_SEL   = 1'h1;
  localparam logic [8:0] ONE_PHASE       = 9'h001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] bit_clock_divide_value;
    logic       sample_clock_source_select;
    logic [1:0] clock_stop_code;
    logic       transmit_clock_polarity;
    logic       transmit_clock_direction;
    logic       receive_clock_direction;
    logic       transmit_frame_direction;
    logic       receive_frame_direction;
    logic       transmit_frame_polarity;
    logic       receive_frame_polarity;
  } scs_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_RUN,
    ST_TAIL
  } scs_state_t;

endpackage

// [design/scs_port.sv]
// Clock-stop serial port core with transmit FIFO
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Synchronous FIFO, flip-flop storage
// ------------------------------------------------------------------
module scs_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock,     // Core clock
  input  wire logic             rst_b,     // Async reset, active low
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Space available
  input  wire logic [WIDTH-1:0] in_data,   // Write word
  output logic                  out_valid, // Word available
  input  wire logic             out_ready, // Read accept
  output logic      [WIDTH-1:0] out_data   // Head word
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Handshakes; full and empty come straight from the count
  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rd_r];

  // Storage writes
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // Pointers and occupancy; wrap handles non power-of-two depths
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ------------------------------------------------------------------
// Port core: master bit clock and select, or slave on external pins
// ------------------------------------------------------------------
module scs_port #(
  parameter int unsigned WORD_W     = 16,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic              clock,                    // Core clock, one P
  input  wire logic              rst_b,                    // Async reset, active low
  input  wire scs_pkg::scs_cfg_t cfg,                      // Static configuration
  input  wire logic              tx_valid,                 // Transmit word offered
  output logic                   tx_ready,                 // FIFO can take word
  input  wire logic [WORD_W-1:0] tx_data,                  // Transmit word
  output logic                   rx_valid,                 // Received word, pulse
  output logic      [WORD_W-1:0] rx_data,                  // Received word
  output logic                   busy,                     // Transfer in progress
  output logic                   sample_rate_clock,        // Internal sample clock
  input  wire logic              serial_bit_clock_in,      // Clock pin, input side
  output logic                   serial_bit_clock_out,     // Clock pin, output side
  output logic                   serial_bit_clock_oe,      // Clock pin drive enable
  input  wire logic              transmit_frame_sync_in,   // Select pin, input side
  output logic                   transmit_frame_sync_out,  // Select pin, output side
  output logic                   transmit_frame_sync_oe,   // Select pin drive enable
  input  wire logic              receive_frame_sync_in,    // Receive select input
  input  wire logic              serial_data_in,           // Data input pin
  output logic                   serial_data_out,          // Data pin, output side
  output logic                   serial_data_oe            // Data pin drive enable
);
  localparam int unsigned EW = $clog2(2 * WORD_W) + 1;
  localparam int unsigned BW = $clog2(WORD_W) + 1;

  scs_pkg::scs_state_t st_r;
  logic [8:0]          cnt_r;
  logic [EW-1:0]       edges_r;
  logic [BW-1:0]       bits_r;
  logic                sclk_r;
  logic                sel_r;
  logic                mdrv_r;
  logic                sampled_r;
  logic [WORD_W-1:0]   tx_sh_r;
  logic [WORD_W-1:0]   rx_sh_r;
  logic                sample_rate_clock_r;
  logic                pin_clk_r;
  logic                s_tx_act_r;
  logic                s_rx_act_r;
  logic                q_valid;
  logic [WORD_W-1:0]   q_data;
  logic                q_pop;
  logic                master;
  logic                launch_rise;
  logic                slave_tick;
  logic                s_tx_act;
  logic                s_rx_act;
  logic                s_start;
  logic                edge_ev;
  logic                new_lvl;
  logic                launch_ev;
  logic                sample_ev;
  logic                m_start;
  logic                m_last;

  // Phase width in P for the given clock level
  function automatic logic [8:0] phase_w(input logic [7:0] d, input logic lvl);
    if (d == scs_pkg::DIV_ZERO) begin
      phase_w = scs_pkg::ONE_PHASE;  // One-P period not realisable; clamp to 2P
    end else if (d[0]) begin
      phase_w = 9'(({1'b0, d} + scs_pkg::ONE_PHASE) >> 1);
    end else begin
      phase_w = {2'b00, d[7:1]} + (lvl ? scs_pkg::ONE_PHASE : 9'h000);
    end
  endfunction

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  scs_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_data)
  );

  // ----------------------------------------------------------------
  // Mode decode and pin directions
  // ----------------------------------------------------------------
  // Master only with both transmit clock and frame driven out
  assign master = (cfg.transmit_clock_direction == scs_pkg::DIR_OUT) &&
                  (cfg.transmit_frame_direction == scs_pkg::DIR_OUT);
  assign serial_bit_clock_oe    = cfg.transmit_clock_direction;
  assign transmit_frame_sync_oe = cfg.transmit_frame_direction;
  // Launch edge: codes 10b/11b swap edges, polarity flips both
  assign launch_rise = cfg.transmit_clock_polarity ^
                       (cfg.clock_stop_code == scs_pkg::STOP_NO_DELAY);

  // Slave select pins inverted when programmed active low
  assign s_tx_act = transmit_frame_sync_in ^
                    (cfg.transmit_frame_polarity == scs_pkg::FRAME_POL_LOW);
  assign s_rx_act = receive_frame_sync_in ^
                    (cfg.receive_frame_polarity == scs_pkg::FRAME_POL_LOW);
  assign s_start  = !master && s_tx_act && !s_tx_act_r;

  // ----------------------------------------------------------------
  // Sample-rate clock; slave looks at the clock pin only on its high phase with source select 1 and divide 01h, else every cycle
  // ----------------------------------------------------------------
  // Toggles every cycle, so it runs at half the core clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sample_rate_clock_r <= 1'b0;
    end else begin
      sample_rate_clock_r <= ~sample_rate_clock_r;
    end
  end

  assign sample_rate_clock = sample_rate_clock_r;
  assign slave_tick = ((cfg.sample_clock_source_select == scs_pkg::SLAVE_SRC_SEL) &&
                       (cfg.bit_clock_divide_value == scs_pkg::SLAVE_DIV)) ? sample_rate_clock_r : 1'b1;

  // ----------------------------------------------------------------
  // Edge events, common to both modes
  // ----------------------------------------------------------------
  always_comb begin
    if (master) begin
      edge_ev = ((st_r == scs_pkg::ST_LEAD) || (st_r == scs_pkg::ST_RUN)) &&
                (cnt_r == scs_pkg::ONE_PHASE);
      new_lvl = ~sclk_r;
    end else begin
      edge_ev = slave_tick && (serial_bit_clock_in != pin_clk_r) && s_tx_act_r;
      new_lvl = serial_bit_clock_in;
    end
  end

  assign launch_ev = edge_ev && (new_lvl == launch_rise);
  assign sample_ev = edge_ev && (new_lvl != launch_rise) && (master || s_rx_act_r);
  assign m_start   = master && (st_r == scs_pkg::ST_IDLE) && q_valid;
  assign m_last    = edge_ev && master && (edges_r == EW'(2 * WORD_W - 1));
  assign q_pop     = (m_start || s_start) && q_valid;

  // ----------------------------------------------------------------
  // Master sequencer: lead-in, clocking, tail, release
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r    <= scs_pkg::ST_IDLE;
      cnt_r   <= scs_pkg::ONE_PHASE;
      edges_r <= '0;
      sclk_r  <= 1'b0;
      sel_r   <= 1'b0;
      mdrv_r  <= 1'b0;
    end else begin
      case (st_r)
        scs_pkg::ST_IDLE: begin
          sclk_r <= cfg.transmit_clock_polarity;
          if (m_start) begin
            sel_r   <= 1'b1;
            mdrv_r  <= 1'b1;
            edges_r <= '0;
            // Lead-in: first phase for 10b, whole period for 11b
            cnt_r   <= (cfg.clock_stop_code == scs_pkg::STOP_HALF_DELAY) ?
                       9'(phase_w(cfg.bit_clock_divide_value, 1'b1) +
                          phase_w(cfg.bit_clock_divide_value, 1'b0)) :
                       phase_w(cfg.bit_clock_divide_value,
                               cfg.transmit_clock_polarity);
            st_r    <= scs_pkg::ST_LEAD;
          end
        end
        scs_pkg::ST_LEAD, scs_pkg::ST_RUN: begin
          if (edge_ev) begin
            sclk_r  <= new_lvl;
            edges_r <= edges_r + 1'b1;
            cnt_r   <= phase_w(cfg.bit_clock_divide_value, new_lvl);
            st_r    <= m_last ? scs_pkg::ST_TAIL : scs_pkg::ST_RUN;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        scs_pkg::ST_TAIL: begin
          // Hold last bit one phase past the final edge, then release
          if (cnt_r == scs_pkg::ONE_PHASE) begin
            mdrv_r <= 1'b0;
            sel_r  <= 1'b0;
            st_r   <= scs_pkg::ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          st_r <= scs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Slave pin history: clock pin taken on sample-rate ticks, selects every cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_clk_r  <= 1'b0;
      s_tx_act_r <= 1'b0;
      s_rx_act_r <= 1'b0;
    end else begin
      if (slave_tick) begin
        pin_clk_r <= serial_bit_clock_in;
      end
      s_tx_act_r <= !master && s_tx_act;
      s_rx_act_r <= !master && s_rx_act;
    end
  end

  // ----------------------------------------------------------------
  // Shift path: load, launch shifts, sample captures
  // ----------------------------------------------------------------
  // First launch edge before any sample keeps the MSB on the line
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_sh_r   <= '0;
      rx_sh_r   <= '0;
      sampled_r <= 1'b0;
      bits_r    <= '0;
    end else begin
      if (m_start || s_start) begin
        tx_sh_r   <= q_valid ? q_data : '0;  // Underrun sends zeros
        sampled_r <= 1'b0;
        bits_r    <= '0;
      end else begin
        if (launch_ev && sampled_r) begin
          tx_sh_r <= {tx_sh_r[WORD_W-2:0], 1'b0};
        end
        if (sample_ev) begin
          rx_sh_r   <= {rx_sh_r[WORD_W-2:0], serial_data_in};
          sampled_r <= 1'b1;
          bits_r    <= (bits_r == BW'(WORD_W - 1)) ? '0 : bits_r + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Received word out, one-cycle pulse on the last sample
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_valid <= 1'b0;
      rx_data  <= '0;
    end else begin
      rx_valid <= sample_ev && (bits_r == BW'(WORD_W - 1));
      if (sample_ev && (bits_r == BW'(WORD_W - 1))) begin
        rx_data <= {rx_sh_r[WORD_W-2:0], serial_data_in};
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  assign serial_bit_clock_out = master ? sclk_r : cfg.transmit_clock_polarity;
  // Internal select active high; inverted onto the pin when polarity is 1
  assign transmit_frame_sync_out = sel_r ^
                                   (cfg.transmit_frame_polarity == scs_pkg::FRAME_POL_LOW);
  assign serial_data_out = tx_sh_r[WORD_W-1];
  // Slave drives only while select is held; release follows select high
  assign serial_data_oe  = master ? mdrv_r : s_tx_act_r;
  assign busy            = master ? (st_r != scs_pkg::ST_IDLE) : s_tx_act_r;
endmodule

`default_nettype wire

// [dv/scs_port_checker.sv]
// Pin-level assertions for the clock-stop serial port
`timescale 1ns/1ps
`default_nettype none
module scs_port_checker #(
  parameter int unsigned WORD_W     = 16,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input wire logic              clock,                   // Core clock
  input wire logic              rst_b,                   // Reset, low
  input wire scs_pkg::scs_cfg_t cfg,                     // Settings
  input wire logic              tx_ready,                // FIFO space
  input wire logic              busy,                    // Frame on
  input wire logic              sample_rate_clock,       // Sample clock
  input wire logic              serial_bit_clock_out,    // Clock out
  input wire logic              serial_bit_clock_oe,     // Clock enable
  input wire logic              transmit_frame_sync_in,  // Select in
  input wire logic              transmit_frame_sync_out, // Select out
  input wire logic              transmit_frame_sync_oe,  // Select enable
  input wire logic              serial_data_out,         // Data out
  input wire logic              serial_data_oe           // Data enable
);
  // ----------------------------------------------------------------
  // Checks, all on the core clock
  // ----------------------------------------------------------------
  wire logic mst = cfg.transmit_clock_direction & cfg.transmit_frame_direction;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  clk_dir_a: assert property (serial_bit_clock_oe == cfg.transmit_clock_direction)
    else $error("clock pin enable differs from direction");
  sel_dir_a: assert property (transmit_frame_sync_oe == cfg.transmit_frame_direction)
    else $error("select pin enable differs from direction");
  samp_toggle_a: assert property ($past(rst_b) |-> sample_rate_clock != $past(sample_rate_clock))
    else $error("sample clock missed a toggle");
  sel_busy_a: assert property (mst && !transmit_frame_sync_out |-> busy)
    else $error("select low while idle");
  clk_idle_a: assert property ($past(rst_b) && mst && transmit_frame_sync_out
    |-> serial_bit_clock_out == cfg.transmit_clock_polarity) else $error("clock not idle");
  lead_hold_a: assert property (mst && $fell(transmit_frame_sync_out) |-> $stable(serial_bit_clock_out))
    else $error("clock edge together with select");
  oe_frame_a: assert property (mst |-> serial_data_oe == !transmit_frame_sync_out)
    else $error("data drive outside frame");
  launch_edge_a: assert property (mst && $past(serial_data_oe) && serial_data_oe && $changed(serial_data_out)
    |-> serial_bit_clock_out != (cfg.transmit_clock_polarity ^ cfg.clock_stop_code[0]))
    else $error("data moved on sample edge");
  slave_release_a: assert property ((!mst && transmit_frame_sync_in) [*4] |-> !serial_data_oe)
    else $error("slave holds data after select high");

  cover property (mst && $fell(transmit_frame_sync_out));
  cover property (!mst && $fell(serial_data_oe));
  cover property (!tx_ready);
endmodule

bind scs_port scs_port_checker #(.WORD_W(WORD_W), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clock(clock), .rst_b(rst_b), .cfg(cfg), .tx_ready(tx_ready), .busy(busy),
  .sample_rate_clock(sample_rate_clock), .serial_bit_clock_out(serial_bit_clock_out),
  .serial_bit_clock_oe(serial_bit_clock_oe), .transmit_frame_sync_in(transmit_frame_sync_in),
  .transmit_frame_sync_out(transmit_frame_sync_out),
  .transmit_frame_sync_oe(transmit_frame_sync_oe), .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe));
`default_nettype wire

// [dv/scs_peer.sv]
// Far-side SPI device: slave to a master port, master to a slave port
`timescale 1ns/1ps
`default_nettype none
module scs_peer #(
  parameter int unsigned W = 16
) (
  input  wire logic         clock,    // Core clock
  input  wire logic         drive,    // Act as master
  input  wire logic         go,       // Start master frame
  input  wire logic [1:0]   code,     // Clock-stop code
  input  wire logic         pol,      // Clock polarity
  input  wire logic [W-1:0] word,     // Word to send
  input  wire logic         sck,      // Clock pin level
  input  wire logic         ss_n,     // Select pin level
  input  wire logic         din,      // Data from port
  output logic              dout,     // Data to port
  output logic              sck_drv,  // Clock when master
  output logic              ss_n_drv, // Select when master
  output logic              active,   // Master frame on
  output logic [W-1:0]      got       // Last word taken
);
  logic [W-1:0] sh = '0;
  logic [W-1:0] rx = '0;
  logic         tgl = 1'b0;
  int           n = 0;
  initial begin
    sck_drv = 1'b1;
    ss_n_drv = 1'b1;
    active = 1'b0;
    got = '0;
  end
  // Unselected line shows a moving pattern so stale bits never pass
  always @(posedge clock) tgl <= ~tgl;
  assign dout = ss_n ? tgl : sh[W-1];
  // Word loads on select low, first bit at once
  always @(negedge ss_n) begin
    sh = word;
    n = 0;
  end
  always @(posedge ss_n) got = rx;
  // Sample on one edge, launch on the other once a bit is in
  always @(sck) if (!ss_n) begin
    if (sck == (pol ^ code[0])) begin
      rx = {rx[W-2:0], din};
      n++;
    end else if (n > 0) sh = {sh[W-2:0], 1'b0};
  end
  // Master role: 8 cycles a phase, the fastest legal slave clock
  always @(posedge clock) if (drive && go && !active) begin
    active <= 1'b1;
    ss_n_drv <= 1'b0;
    repeat (8) @(posedge clock);
    repeat (2 * W) begin
      sck_drv <= ~sck_drv;
      repeat (8) @(posedge clock);
    end
    ss_n_drv <= 1'b1;
    repeat (8) @(posedge clock);
    active <= 1'b0;
  end else sck_drv <= pol; // Idle level follows polarity between frames
endmodule
`default_nettype wire

// [dv/scs_port_tb.sv]
// Self-checking bench for the clock-stop serial port
`timescale 1ns/1ps
`default_nettype none
module scs_port_tb;
  logic              clock = 1'b0;
  logic              rst_b = 1'b0;
  logic              tx_valid = 1'b0;
  logic              go = 1'b0;
  logic [15:0]       tx_data = 16'h0000;
  logic [15:0]       pw = 16'h0000;
  logic [31:0]       lfsr = 32'h0000_166b;
  scs_pkg::scs_cfg_t cfg = '0;
  int                bad_count = 0;
  int                cmp_count = 0;
  wire logic tx_ready, rx_valid, busy, sck_o, sck_oe, ss_o, ss_oe, d_o, d_oe, pd, psck, pss, act;
  wire logic [15:0] rx_data, got;
  wire logic mst = cfg.transmit_clock_direction;
  // Pin levels from whichever side drives them
  wire logic sck = sck_oe ? sck_o : psck;
  wire logic ss_n = ss_oe ? ss_o : pss;
  wire logic mosi = d_oe ? d_o : ~d_o;

  scs_port #(.WORD_W(16), .FIFO_DEPTH(8)) dut (
    .clock(clock), .rst_b(rst_b), .cfg(cfg), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy),
    .sample_rate_clock(), .serial_bit_clock_in(sck), .serial_bit_clock_out(sck_o),
    .serial_bit_clock_oe(sck_oe), .transmit_frame_sync_in(ss_n), .transmit_frame_sync_out(ss_o),
    .transmit_frame_sync_oe(ss_oe), .receive_frame_sync_in(ss_n), .serial_data_in(pd),
    .serial_data_out(d_o), .serial_data_oe(d_oe));
  scs_peer #(.W(16)) peer (.clock(clock), .drive(!mst), .go(go), .code(cfg.clock_stop_code),
    .pol(cfg.transmit_clock_polarity), .word(pw), .sck(sck), .ss_n(ss_n), .din(mosi),
    .dout(pd), .sck_drv(psck), .ss_n_drv(pss), .active(act), .got(got));

  initial forever #25 clock = ~clock;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // Divide 0 cannot split one P, so each phase takes one P
  function automatic int lo_w(int d);
    return (d == 0) ? 1 : d[0] ? (d + 1) / 2 : d / 2;
  endfunction
  function automatic int hi_w(int d);
    return (d == 0) ? 1 : d[0] ? (d + 1) / 2 : d / 2 + 1;
  endfunction
  function automatic int lead_w(int d);
    if (cfg.clock_stop_code == scs_pkg::STOP_HALF_DELAY) return lo_w(d) + hi_w(d);
    return cfg.transmit_clock_polarity ? hi_w(d) : lo_w(d);
  endfunction
  function automatic scs_pkg::scs_cfg_t mk(logic m, logic [7:0] d, logic [1:0] c, logic p);
    scs_pkg::scs_cfg_t r;
    r = '0;
    r.bit_clock_divide_value = m ? d : scs_pkg::SLAVE_DIV;
    r.sample_clock_source_select = m ? 1'b0 : scs_pkg::SLAVE_SRC_SEL;
    r.clock_stop_code = c;
    r.transmit_clock_polarity = p;
    r.transmit_clock_direction = m;
    r.transmit_frame_direction = m;
    r.transmit_frame_polarity = scs_pkg::FRAME_POL_LOW;
    r.receive_frame_polarity = scs_pkg::FRAME_POL_LOW;
    return r;
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
    cmp_count++;
    if (exp !== seen) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Settings are static, so each change goes in under reset
  task automatic setup(scs_pkg::scs_cfg_t c);
    rst_b <= 1'b0;
    cfg <= c;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
  endtask
  task automatic wait_rx();
    int i;
    i = 0;
    while (rx_valid !== 1'b1 && i < 4000) begin
      @(posedge clock);
      i++;
    end
    check("rx timeout", 0, i >= 4000);
  endtask
  task automatic wait_idle();
    int i;
    i = 0;
    while ((busy !== 1'b0 || act !== 1'b0) && i < 4000) begin
      @(posedge clock);
      i++;
    end
    check("idle timeout", 0, i >= 4000);
  endtask

  // Phase and lead widths in core cycles, one cycle being one P
  logic clk_q = 1'b1;
  logic sel_q = 1'b1;
  logic first = 1'b0;
  int   rcnt = 0;
  int   lcnt = 0;
  always @(posedge clock) begin
    rcnt++;
    lcnt++;
    if (rst_b && mst && sel_q && !ss_o) begin
      lcnt = 0;
      first = 1'b1;
    end
    if (rst_b && mst && !ss_o && sck_o !== clk_q) begin
      if (first) check("lead", lead_w(cfg.bit_clock_divide_value), lcnt);
      else if (clk_q) check("high", hi_w(cfg.bit_clock_divide_value), rcnt);
      else check("low", lo_w(cfg.bit_clock_divide_value), rcnt);
      first = 1'b0;
      rcnt = 0;
    end
    clk_q = sck_o;
    sel_q = ss_o;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic mframe(logic [7:0] d, logic [1:0] c, logic p);
    logic [31:0] v;
    setup(mk(1'b1, d, c, p));
    v = nxt();
    pw <= v[31:16];
    tx_valid <= 1'b1;
    tx_data <= v[15:0];
    @(posedge clock);
    tx_valid <= 1'b0;
    wait_rx();
    check("master rx", pw, rx_data);
    wait_idle();
    check("peer got", v[15:0], got);
  endtask
  // Fill the FIFO while unselected, then one slave frame drains a word
  task automatic sframe(logic [1:0] c, logic p);
    logic [31:0] v;
    logic [15:0] f;
    int          n;
    setup(mk(1'b0, 8'h00, c, p));
    n = 0;
    v = nxt();
    f = v[15:0];
    tx_data <= v[15:0];
    tx_valid <= 1'b1;
    // Word moves on only once taken, so a full FIFO sees a steady offer
    repeat (12) begin
      @(posedge clock);
      if (tx_ready === 1'b1) begin
        n++;
        v = nxt();
        tx_data <= v[15:0];
      end
    end
    tx_valid <= 1'b0;
    check("fifo words", 8, n);
    pw <= v[31:16];
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    wait_rx();
    check("slave rx", pw, rx_data);
    wait_idle();
    check("slave tx", f, got);
    check("fifo space", 1, tx_ready);
  endtask

  initial begin
    int d;
    cfg <= mk(1'b1, 8'h01, scs_pkg::STOP_NO_DELAY, 1'b1);
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 12; i++) begin
      d = (i < 6) ? i : int'(nxt() % 10);
      for (int m = 0; m < 4; m++) begin
        mframe(8'(d), m[1] ? scs_pkg::STOP_HALF_DELAY : scs_pkg::STOP_NO_DELAY, m[0]);
      end
    end
    for (int m = 0; m < 4; m++) begin
      sframe(m[1] ? scs_pkg::STOP_HALF_DELAY : scs_pkg::STOP_NO_DELAY, m[0]);
    end
    report_and_stop();
  end
  // Under 7500 cycles expected; eight times that means a hang
  initial begin
    #(50 * 60000);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
